// ### logic/vpr_pkg.sv
package vpr_pkg;

    // Register bus shape
    localparam int          VPR_ADDR_W  = 4;
    localparam int          VPR_DATA_W  = 16;

    // Register offsets
    localparam logic [3:0]  VPR_ADDR_PRIO   = 4'h0;
    localparam logic [3:0]  VPR_ADDR_ENABLE = 4'h1;
    localparam logic [3:0]  VPR_ADDR_TIMER  = 4'h2;
    localparam logic [3:0]  VPR_ADDR_STATUS = 4'h3;
    localparam logic [3:0]  VPR_ADDR_MASK   = 4'h4;
    localparam logic [3:0]  VPR_ADDR_VECTOR = 4'h5;

    // Source table, highest vector address first
    localparam int          VPR_NUM_SRC        = 24;
    localparam int          VPR_FIRST_MASKABLE = 6;
    localparam int          VPR_SRC_RST        = 0;
    localparam int          VPR_SRC_CLKMON     = 1;
    localparam int          VPR_SRC_WDOG       = 2;
    localparam int          VPR_SRC_TRAP       = 3;
    localparam int          VPR_SRC_SWTRAP     = 4;
    localparam int          VPR_SRC_NMI_PIN    = 5;
    localparam int          VPR_SRC_PIN        = 6;
    localparam int          VPR_SRC_TICK       = 7;
    localparam int          VPR_SRC_TMR0       = 8;
    localparam int          VPR_NUM_TMR        = 8;
    localparam int          VPR_SRC_TOVF       = 16;
    localparam int          VPR_SRC_ACC_OVF    = 17;
    localparam int          VPR_SRC_ACC_EDGE   = 18;
    localparam int          VPR_SRC_SPI        = 19;
    localparam int          VPR_SRC_CAN_ERR    = 20;
    localparam int          VPR_SRC_CAN_TX     = 21;
    localparam int          VPR_SRC_PWM_SD     = 22;
    localparam int          VPR_SRC_LVI        = 23;

    // Vector high byte and per-source low byte (entry i at [i*8 +: 8])
    localparam logic [7:0]  VPR_VEC_HIGH = 8'hFF;
    localparam logic [VPR_NUM_SRC*8-1:0] VPR_VEC_LOW = {
        8'h8A, 8'h8C, 8'hB0, 8'hB4, 8'hD8, 8'hDA, 8'hDC, 8'hDE,
        8'hE0, 8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC, 8'hEE,
        8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA, 8'hFC, 8'hFE};

    // Enable register bit positions
    localparam int          VPR_EN_PIN      = 0;
    localparam int          VPR_EN_TICK     = 1;
    localparam int          VPR_EN_TOVF     = 2;
    localparam int          VPR_EN_ACC_OVF  = 3;
    localparam int          VPR_EN_ACC_EDGE = 4;
    localparam int          VPR_EN_SPI_RX   = 5;
    localparam int          VPR_EN_SPI_TX   = 6;
    localparam int          VPR_EN_CAN_SC   = 7;
    localparam int          VPR_EN_CAN_OVR  = 8;
    localparam int          VPR_EN_CAN_TXE  = 9;
    localparam int          VPR_EN_PWM_SD   = 12;
    localparam int          VPR_EN_LVI      = 13;
    localparam int          VPR_EN_CME      = 14;
    localparam int          VPR_EN_CLOCK_MONITOR_FORCE_ENABLE     = 15;

    // Timer/watchdog register fields and CAN transmit buffer count
    localparam int          VPR_TMR_RATE_LSB = 8;
    localparam int          VPR_RATE_W       = 3;
    localparam int          VPR_CAN_TX_N     = 3;

    // Status width: one sticky flag per non-maskable source
    localparam int          VPR_ST_W = 6;

    // Start-up values
    localparam logic [7:0]  VPR_PRIO_RST   = 8'hF2;
    localparam logic [15:0] VPR_ENABLE_RST = 16'h0000;
    localparam logic [15:0] VPR_TIMER_RST  = 16'h0000;
    localparam logic [5:0]  VPR_MASK_RST   = 6'h00;
    localparam logic [5:0]  VPR_STATUS_RST = 6'h00;

endpackage

// ### logic/vpr_top.sv
`timescale 1ns/10ps

// Contract
// - Higher vector address wins over every lower-address source, except that an elevated maskable one beats the other maskable ones.
// - Power-on, pin and low-voltage resets all vector at FFFE, unmasked.
// - Clock monitor failure resets via FFFC, enabled by monitor enables.
// - Reset ranking: rank1 resets, then clock monitor, then watchdog FFFA.
// - Unimplemented opcode traps via FFF8 with no mask or enable.
// - Elevation register holding a source's low byte makes it top maskable.
// - Eight timer channels vector FFEE down to FFE0, gated by I and enable.
// - Timer overflow vectors FFDE, gated by overflow enable.
// - Accumulator overflow FFDC and edge FFDA, each with own enable.
// - Serial receive and transmit requests share FFD8, each enabled.
// - CAN error vector on status change or overrun, each enabled.
// - CAN transmit vector when an enabled transmit buffer is empty.
// - Reduced variant has no CAN vectors; they stay reserved.
// - Shutdown event vectors FF8C, gated by shutdown enable, elevation 8C.
// - Regulator low-voltage indication vectors FF8A, elevation 8A.
// - Any reset returns registers and control bits, except the status flags, to start-up values.
// - Reset never clears or initialises on-chip RAM.
module vpr_top #(
    parameter bit REDUCED_VARIANT = 1'b0
) (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic [vpr_pkg::VPR_ADDR_W-1:0] addr_in,
    input  wire logic [vpr_pkg::VPR_DATA_W-1:0] wr_data_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [vpr_pkg::VPR_DATA_W-1:0] rd_data_out,
    input  wire logic                        power_on_reset_in,
    input  wire logic                        ext_reset_in,
    input  wire logic                        low_voltage_reset_in,
    input  wire logic                        clock_fail_in,
    input  wire logic                        watchdog_timeout_in,
    input  wire logic                        bad_opcode_in,
    input  wire logic                        software_trap_in,
    input  wire logic                        nonmaskable_pin_request_in,
    input  wire logic                        pin_request_in,
    input  wire logic                        tick_in,
    input  wire logic [7:0]                  timer_channel_in,
    input  wire logic                        timer_overflow_in,
    input  wire logic                        acc_overflow_in,
    input  wire logic                        acc_edge_in,
    input  wire logic                        spi_rx_in,
    input  wire logic                        spi_tx_in,
    input  wire logic                        can_status_change_in,
    input  wire logic                        can_overrun_in,
    input  wire logic [2:0]                  can_tx_empty_in,
    input  wire logic                        pwm_shutdown_in,
    input  wire logic                        low_voltage_ind_in,
    input  wire logic                        cc_i_mask_in,
    input  wire logic                        cc_x_mask_in,
    output logic      [15:0]                 vector_out,
    output logic                             int_pending_out,
    output logic                             reset_req_out,
    output logic                             irq_out
);

    localparam int N  = vpr_pkg::VPR_NUM_SRC;
    localparam int FM = vpr_pkg::VPR_FIRST_MASKABLE;
    localparam int SW = vpr_pkg::VPR_ST_W;

    // Control registers
    logic [7:0]  prio_q;
    logic [15:0] enable_q;
    logic [15:0] timer_q;
    logic [SW-1:0] status_q;
    logic [SW-1:0] status_d;
    logic [SW-1:0] mask_q;
    logic [15:0] rd_data_d;
    logic [15:0] rd_data_q;

    // Output flops
    logic [15:0] vector_q;
    logic        pending_q;
    logic        reset_req_q;
    logic        irq_q;

    // Gated requests and arbitration
    wire logic [N-1:0]    active;
    wire logic [N-FM-1:0] elev_hit;
    logic                 found;
    logic [7:0]           pick;
    logic [15:0]          vector_d;
    logic                 reset_event;
    logic                 can_ok;
    logic                 clkmon_en;
    logic                 wdog_en;
    logic                 wr_status;

    assign can_ok    = !REDUCED_VARIANT;
    assign clkmon_en = enable_q[vpr_pkg::VPR_EN_CME]
                     | enable_q[vpr_pkg::VPR_EN_CLOCK_MONITOR_FORCE_ENABLE];
    // A nonzero rate selection is what arms the watchdog
    assign wdog_en   = |timer_q[vpr_pkg::VPR_TMR_RATE_LSB +: vpr_pkg::VPR_RATE_W];
    assign wr_status = wr_in && (addr_in == vpr_pkg::VPR_ADDR_STATUS);

    // Non-maskable sources: resets, traps and the X-gated pin
    assign active[vpr_pkg::VPR_SRC_RST] = power_on_reset_in
        | ext_reset_in | low_voltage_reset_in;
    assign active[vpr_pkg::VPR_SRC_CLKMON] =
        clock_fail_in & clkmon_en;
    assign active[vpr_pkg::VPR_SRC_WDOG] =
        watchdog_timeout_in & wdog_en;
    assign active[vpr_pkg::VPR_SRC_TRAP]   = bad_opcode_in;
    assign active[vpr_pkg::VPR_SRC_SWTRAP] = software_trap_in;
    assign active[vpr_pkg::VPR_SRC_NMI_PIN] =
        nonmaskable_pin_request_in & !cc_x_mask_in;

    // Maskable sources, each behind the I bit and its local enable
    assign active[vpr_pkg::VPR_SRC_PIN] = pin_request_in
        & enable_q[vpr_pkg::VPR_EN_PIN] & !cc_i_mask_in;
    assign active[vpr_pkg::VPR_SRC_TICK] = tick_in
        & enable_q[vpr_pkg::VPR_EN_TICK] & !cc_i_mask_in;
    assign active[vpr_pkg::VPR_SRC_TOVF] = timer_overflow_in
        & enable_q[vpr_pkg::VPR_EN_TOVF] & !cc_i_mask_in;
    assign active[vpr_pkg::VPR_SRC_ACC_OVF] = acc_overflow_in
        & enable_q[vpr_pkg::VPR_EN_ACC_OVF] & !cc_i_mask_in;
    assign active[vpr_pkg::VPR_SRC_ACC_EDGE] = acc_edge_in
        & enable_q[vpr_pkg::VPR_EN_ACC_EDGE] & !cc_i_mask_in;
    assign active[vpr_pkg::VPR_SRC_SPI] = !cc_i_mask_in
        & ((spi_rx_in & enable_q[vpr_pkg::VPR_EN_SPI_RX])
         | (spi_tx_in & enable_q[vpr_pkg::VPR_EN_SPI_TX]));
    // CAN lines are forced off on the reduced variant
    assign active[vpr_pkg::VPR_SRC_CAN_ERR] = can_ok & !cc_i_mask_in
        & ((can_status_change_in & enable_q[vpr_pkg::VPR_EN_CAN_SC])
         | (can_overrun_in & enable_q[vpr_pkg::VPR_EN_CAN_OVR]));
    assign active[vpr_pkg::VPR_SRC_CAN_TX] = can_ok & !cc_i_mask_in
        & (|(can_tx_empty_in
        & enable_q[vpr_pkg::VPR_EN_CAN_TXE +: vpr_pkg::VPR_CAN_TX_N]));
    assign active[vpr_pkg::VPR_SRC_PWM_SD] = pwm_shutdown_in
        & enable_q[vpr_pkg::VPR_EN_PWM_SD] & !cc_i_mask_in;
    assign active[vpr_pkg::VPR_SRC_LVI] = low_voltage_ind_in
        & enable_q[vpr_pkg::VPR_EN_LVI] & !cc_i_mask_in;

    // Timer channels, channel 0 in the highest slot
    genvar g;
    generate
        for (g = 0; g < vpr_pkg::VPR_NUM_TMR; g++) begin : g_tmr
            assign active[vpr_pkg::VPR_SRC_TMR0 + g] = timer_channel_in[g]
                & timer_q[g] & !cc_i_mask_in;
        end
        // Elevation match: active maskable source whose low byte is loaded
        for (g = FM; g < N; g++) begin : g_elev
            assign elev_hit[g - FM] = active[g]
                && (vpr_pkg::VPR_VEC_LOW[g*8 +: 8] == prio_q);
        end
    endgenerate

    // Fixed-order search, then elevation override among maskable ones
    always_comb begin
        found = 1'b0;
        pick  = '0;
        for (int i = 0; i < N; i++) begin
            if (!found && active[i]) begin
                found = 1'b1;
                pick  = vpr_pkg::VPR_VEC_LOW[i*8 +: 8];
            end
        end
        // Elevation never climbs above traps or resets
        if (!(|active[FM-1:0]) && (|elev_hit)) begin
            pick = prio_q;
        end
        vector_d = {vpr_pkg::VPR_VEC_HIGH, pick};
    end

    // Any reset-class source, ranked by the search above
    assign reset_event = |active[vpr_pkg::VPR_SRC_WDOG:vpr_pkg::VPR_SRC_RST];

    // Vector presented to the core, one cycle behind the requests
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            vector_q  <= {vpr_pkg::VPR_VEC_HIGH,
                          vpr_pkg::VPR_VEC_LOW[0 +: 8]};
            pending_q <= 1'b0;
        end else begin
            vector_q  <= found ? vector_d : vector_q;
            pending_q <= found;
        end
    end

    // Reset request to the system, level while a reset source stands
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reset_req_q <= 1'b0;
        end else begin
            reset_req_q <= reset_event;
        end
    end

    // Elevation register; a reset event wins over a write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prio_q <= vpr_pkg::VPR_PRIO_RST;
        end else if (reset_event) begin
            prio_q <= vpr_pkg::VPR_PRIO_RST;
        end else if (wr_in && addr_in == vpr_pkg::VPR_ADDR_PRIO) begin
            prio_q <= wr_data_in[7:0];
        end
    end

    // Local enables and timer/watchdog control
    // Soft reset touches flops only; no memory array is held here
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            enable_q <= vpr_pkg::VPR_ENABLE_RST;
            timer_q  <= vpr_pkg::VPR_TIMER_RST;
        end else if (reset_event) begin
            enable_q <= vpr_pkg::VPR_ENABLE_RST;
            timer_q  <= vpr_pkg::VPR_TIMER_RST;
        end else if (wr_in) begin
            if (addr_in == vpr_pkg::VPR_ADDR_ENABLE) begin
                enable_q <= wr_data_in;
            end else if (addr_in == vpr_pkg::VPR_ADDR_TIMER) begin
                timer_q  <= wr_data_in;
            end
        end
    end

    // Sticky cause flags survive soft reset so software can tell sources apart
    always_comb begin
        status_d = status_q;
        if (wr_status) begin
            status_d = status_d & ~wr_data_in[SW-1:0];
        end
        status_d = status_d | active[SW-1:0];                   // set beats clear
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_q <= vpr_pkg::VPR_STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // Interrupt mask, same layout as the status flags
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask_q <= vpr_pkg::VPR_MASK_RST;
        end else if (reset_event) begin
            mask_q <= vpr_pkg::VPR_MASK_RST;
        end else if (wr_in && addr_in == vpr_pkg::VPR_ADDR_MASK) begin
            mask_q <= wr_data_in[SW-1:0];
        end
    end

    // Level interrupt from any unmasked flag
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_d & mask_q);
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        rd_data_d = '0;
        if (addr_in == vpr_pkg::VPR_ADDR_PRIO) begin
            rd_data_d[7:0] = prio_q;
        end else if (addr_in == vpr_pkg::VPR_ADDR_ENABLE) begin
            rd_data_d = enable_q;
        end else if (addr_in == vpr_pkg::VPR_ADDR_TIMER) begin
            rd_data_d = timer_q;
        end else if (addr_in == vpr_pkg::VPR_ADDR_STATUS) begin
            rd_data_d[SW-1:0] = status_q;
        end else if (addr_in == vpr_pkg::VPR_ADDR_MASK) begin
            rd_data_d[SW-1:0] = mask_q;
        end else if (addr_in == vpr_pkg::VPR_ADDR_VECTOR) begin
            rd_data_d = vector_q;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_in ? rd_data_d : '0;
        end
    end

    assign rd_data_out     = rd_data_q;
    assign vector_out      = vector_q;
    assign int_pending_out = pending_q;
    assign reset_req_out   = reset_req_q;
    assign irq_out         = irq_q;

    // Checks
    localparam logic [15:0] VEC_RST  = 16'hFFFE;
    localparam logic [15:0] VEC_CM   = 16'hFFFC;
    localparam logic [15:0] VEC_WD   = 16'hFFFA;
    localparam logic [15:0] VEC_TRAP = 16'hFFF8;
    localparam logic [15:0] VEC_T0   = 16'hFFEE;
    localparam logic [15:0] VEC_CERR = 16'hFFB4;
    localparam logic [15:0] VEC_CTX  = 16'hFFB0;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_rank1_vector: assert property (
        active[vpr_pkg::VPR_SRC_RST] |=> vector_q == VEC_RST && reset_req_q)
        else $error("rank one reset did not vector to top pair");
    a_clkmon_vector: assert property (
        clock_fail_in && clkmon_en && !active[vpr_pkg::VPR_SRC_RST]
        |=> vector_q == VEC_CM)
        else $error("clock monitor reset vector wrong");
    a_wdog_rank: assert property (
        watchdog_timeout_in && wdog_en && !(|active[1:0])
        |=> vector_q == VEC_WD && reset_req_q)
        else $error("watchdog reset vector or rank wrong");
    a_wdog_off: assert property (
        !wdog_en && !(|active[1:0]) |=> !reset_req_q)
        else $error("reset raised without an armed source");
    a_trap_vector: assert property (
        bad_opcode_in && !(|active[2:0]) |=> vector_q == VEC_TRAP)
        else $error("opcode trap vector wrong");
    a_imask_block: assert property (
        cc_i_mask_in && !(|active[FM-1:0]) |=> !pending_q)
        else $error("maskable source passed with I set");
    a_elev_tick: assert property (
        active[vpr_pkg::VPR_SRC_TICK] && !(|active[FM-1:0])
        && prio_q == vpr_pkg::VPR_VEC_LOW[vpr_pkg::VPR_SRC_TICK*8 +: 8]
        |=> vector_q == {vpr_pkg::VPR_VEC_HIGH, $past(prio_q)})
        else $error("elevated source not presented");
    a_timer_zero: assert property (
        active[vpr_pkg::VPR_SRC_TMR0] && !(|active[vpr_pkg::VPR_SRC_TMR0-1:0])
        && !(|elev_hit) |=> vector_q == VEC_T0)
        else $error("timer channel zero vector wrong");
    a_can_absent: assert property (
        REDUCED_VARIANT |-> vector_q != VEC_CERR && vector_q != VEC_CTX)
        else $error("CAN vector on reduced variant");
    a_soft_reset: assert property (
        reset_event |=> prio_q == vpr_pkg::VPR_PRIO_RST
        && enable_q == vpr_pkg::VPR_ENABLE_RST && mask_q == '0)
        else $error("registers not restored on reset event");
    a_status_sticky: assert property (
        active[vpr_pkg::VPR_SRC_RST] |=> status_q[vpr_pkg::VPR_SRC_RST])
        else $error("reset cause flag lost");
    a_irq_level: assert property (
        ##1 irq_q == |($past(status_d) & $past(mask_q)))
        else $error("interrupt output does not follow flags");

    c_rank1: cover property (active[vpr_pkg::VPR_SRC_RST] ##1 reset_req_q);
    c_elev: cover property (|elev_hit && !(|active[FM-1:0]));
    c_timer: cover property (active[vpr_pkg::VPR_SRC_TMR0] ##1 pending_q);
    c_cantx: cover property (active[vpr_pkg::VPR_SRC_CAN_TX]);

endmodule // vpr_top

// ### tb/tb_vector_priority_reset_map.sv
`timescale 1ns/10ps

module tb_vector_priority_reset_map;
    logic        clk_in     = 1'b0;
    logic        rst_in     = 1'b1;
    logic [3:0]  addr_in    = 4'h0;
    logic [15:0] wr_data_in = 16'h0000;
    logic        wr_in      = 1'b0;
    logic        rd_in      = 1'b0;
    logic [23:0] src        = 24'h000000;
    logic [15:0] rd_data_out;
    logic [15:0] vector_out;
    logic        int_pending_out;
    logic        reset_req_out;
    logic        irq_out;
    logic        cc_i;
    logic        cc_x;
    int          n_mismatch = 0;
    int          compares   = 0;
    int          seed       = 8;
    int          m_rate     = 0;
    int          m_cme      = 0;
    logic [7:0]  m_prio     = 8'hF2;

    // 100 ns clock
    always #50 clk_in = ~clk_in;

    vpr_core_model core_u (.clk_in, .vector_in(vector_out),
        .int_pending_in(int_pending_out), .cc_i_mask_out(cc_i),
        .cc_x_mask_out(cc_x));

    // Sources packed by priority index; few spare inputs tied off
    vpr_top dut_u (.clk_in, .rst_in, .addr_in, .wr_data_in, .wr_in,
        .rd_in, .rd_data_out, .power_on_reset_in(src[0]),
        .ext_reset_in(1'b0), .low_voltage_reset_in(1'b0),
        .clock_fail_in(src[1]), .watchdog_timeout_in(src[2]),
        .bad_opcode_in(src[3]), .software_trap_in(src[4]),
        .nonmaskable_pin_request_in(src[5]), .pin_request_in(src[6]),
        .tick_in(src[7]), .timer_channel_in(src[15:8]),
        .timer_overflow_in(src[16]), .acc_overflow_in(src[17]),
        .acc_edge_in(src[18]), .spi_rx_in(src[19]), .spi_tx_in(1'b0),
        .can_status_change_in(src[20]), .can_overrun_in(1'b0),
        .can_tx_empty_in({2'b00, src[21]}), .pwm_shutdown_in(src[22]),
        .low_voltage_ind_in(src[23]), .cc_i_mask_in(cc_i),
        .cc_x_mask_in(cc_x), .vector_out, .int_pending_out,
        .reset_req_out, .irq_out);

    function automatic logic [7:0] low(input int i);
        return vpr_pkg::VPR_VEC_LOW[i*8 +: 8];
    endfunction

    // Reference arbiter: index of the winner, -1 when none
    function automatic int exp_idx(input logic [23:0] s);
        if (s[0]) return 0;
        if (s[1] && m_cme != 0) return 1;
        if (s[2] && m_rate != 0) return 2;
        if (s[3]) return 3;
        if (s[4]) return 4;
        if (s[5] && !cc_x) return 5;
        if (cc_i) return -1;
        for (int i = 6; i < 24; i++) if (s[i] && low(i) == m_prio) return i;
        for (int i = 6; i < 24; i++) if (s[i]) return i;
        return -1;
    endfunction

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_in      <= 1'b1;
        @(posedge clk_in);
        wr_in      <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        chk(rd_data_out, e);
    endtask

    // All enables on, watchdog armed, chosen elevation
    task setup(input logic [7:0] p);
        wr(4'h1, 16'hFFFF);
        wr(4'h2, 16'h01FF);
        wr(4'h0, {8'h00, p});
        m_cme  = 1;
        m_rate = 1;
        m_prio = p;
    endtask

    // Two-cycle request burst, answer checked a cycle later
    task apply(input logic [23:0] s);
        int e;
        // Masks set by the core land before the next edge; read them after it
        @(posedge clk_in);
        src <= s;
        e = exp_idx(s);
        @(posedge clk_in);
        #1;
        chk(16'(int_pending_out), 16'(e >= 0));
        chk(16'(reset_req_out), 16'(e >= 0 && e <= 2));
        if (e >= 0) chk(vector_out, {8'hFF, low(e)});
        if (e >= 0 && e <= 2) begin
            m_prio = 8'hF2;
            m_rate = 0;
            m_cme  = 0;
        end
        @(posedge clk_in);
        src <= 24'h000000;
        #1;
    endtask

    task summarize;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard, well past the expected run length
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end

    // Main sequence
    initial begin
        int          r;
        logic [23:0] s;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(4'h0, 16'h00F2);
        rd(4'h1, 16'h0000);
        rd(4'h2, 16'h0000);
        rd(4'h6, 16'h0000);
        setup(8'hF2);
        wr(4'h4, 16'h0008);
        apply(24'h000008);
        chk(16'(irq_out), 16'h0001);
        rd(4'h3, 16'h0008);
        wr(4'h3, 16'h0008);
        rd(4'h3, 16'h0000);
        apply(24'h000010);
        chk(16'(irq_out), 16'h0000);
        for (int i = 6; i < 24; i++) apply(24'(1) << i);
        core_u.set_masks(1'b1, 1'b0);
        apply(24'hFFFFC0);
        apply(24'hFFFFE0);
        core_u.set_masks(1'b0, 1'b1);
        apply(24'h000020);
        core_u.set_masks(1'b0, 1'b0);
        setup(8'h8A);
        apply(24'hFFFFC0);
        setup(8'h8C);
        apply(24'hC00040);
        apply(24'h000004);
        rd(4'h2, 16'h0000);
        rd(4'h0, 16'h00F2);
        apply(24'h000006);
        setup(8'hF0);
        apply(24'h000086);
        setup(8'hF2);
        apply(24'hFFFFFF);
        repeat (40) begin
            r = $random(seed);
            s = r[23:0] & 24'hFFFFC0;
            if (r[31:29] == 3'b000) s[r[28:26] % 6] = 1'b1;
            core_u.set_masks(r[25], r[24]);
            if (m_rate == 0) setup(low(6 + int'(r[30:26]) % 18));
            apply(s);
        end
        summarize();
    end
endmodule // tb_vector_priority_reset_map

// ### tb/vpr_core_model.sv
`timescale 1ns/10ps

// Core side: owns the condition-code mask bits and logs vector fetches
module vpr_core_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] vector_in,
    input  wire logic        int_pending_in,
    output logic             cc_i_mask_out,
    output logic             cc_x_mask_out
);
    int          taken_q = 0;
    logic [15:0] last_q  = 16'h0000;

    // Both masks open out of reset
    initial begin
        cc_i_mask_out = 1'b0;
        cc_x_mask_out = 1'b0;
    end

    // Mask change lands by nonblocking write at the calling time, with no wait for an edge
    task set_masks(input logic i_bit, input logic x_bit);
        cc_i_mask_out <= i_bit;
        cc_x_mask_out <= x_bit;
    endtask

    // Fetch log, only for inspection
    always @(posedge clk_in) begin
        if (int_pending_in) begin
            taken_q <= taken_q + 1;
            last_q  <= vector_in;
        end
    end
endmodule // vpr_core_model
